//--- emu_edge_mask_unit.sv
// Purpose: partial-store edge mask for scan line start and end
// Assumes: operands valid in the cycle they are presented
// Notes: mask registered once so the output comes from a flip-flop
//
// Contract
// - Align both addresses by clearing their three lowest bits.
// - Aligned addresses differ: result is the left edge mask.
// - Aligned addresses equal: result is left AND right mask.
// - No ordering check; aligned start above aligned end still yields left mask.
// - Big-endian: left sets from start offset on; right up to end offset.
// - Little-endian masks are bit-reversed big-endian masks.
// - Left mask from start low bits, right mask from end low bits.
// - One bit per element: eight, four or two bits by size.
// - Set bit enables element write; big-endian byte offset three gives 00011111.
`timescale 1ns/10ps
module emu_edge_mask_unit
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Operands
	input wire logic [emu_pkg::EMU_ADDR_W-1:0] start_elem_ptr_i,
	input wire logic [emu_pkg::EMU_ADDR_W-1:0] last_elem_ptr_i,
	input wire emu_pkg::emu_size_t elem_size_i,
	input wire logic little_endian_i,
	// Result
	output logic [emu_pkg::EMU_MASK_W-1:0] edge_mask_o
);
	import emu_pkg::*;

	logic [EMU_MASK_W-1:0] mask_reg;
	logic [EMU_MASK_W-1:0] mask_next;
	logic [EMU_ADDR_W-1:0] start_al;
	logic [EMU_ADDR_W-1:0] last_al;
	logic [EMU_OFS_W-1:0] lofs;
	logic [EMU_OFS_W-1:0] rofs;
	logic [EMU_MASK_W-1:0] left_be;
	logic [EMU_MASK_W-1:0] right_be;
	logic [EMU_MASK_W-1:0] left_m;
	logic [EMU_MASK_W-1:0] right_m;
	logic [3:0] nelem;

	function automatic logic [EMU_MASK_W-1:0] rev_n(input logic [EMU_MASK_W-1:0] v,
		input logic [3:0] n);
		logic [EMU_MASK_W-1:0] r;
		r = EMU_MASK_RST;
		for (int i = 0; i < EMU_MASK_W; i++)
		begin
			if (i < int'(n))
			begin
				r[i] = v[int'(n) - 1 - i];
			end
		end
		return r;
	endfunction

	always_comb
	begin
		start_al = start_elem_ptr_i & ~EMU_ALIGN_CLR;
		last_al = last_elem_ptr_i & ~EMU_ALIGN_CLR;
		// Offset in elements; bits below element size are dropped
		case (elem_size_i)
			EMU_SIZE_16:
			begin
				lofs = {1'b0, start_elem_ptr_i[2:1]};
				rofs = {1'b0, last_elem_ptr_i[2:1]};
				nelem = 4'h4;
			end
			EMU_SIZE_32:
			begin
				lofs = {2'b00, start_elem_ptr_i[2]};
				rofs = {2'b00, last_elem_ptr_i[2]};
				nelem = 4'h2;
			end
			default:
			begin
				lofs = start_elem_ptr_i[2:0];
				rofs = last_elem_ptr_i[2:0];
				nelem = 4'h8;
			end
		endcase
		// Big-endian with element 0 in the top used bit: ones from offset onward
		left_be = 8'(EMU_ALL_ONES >> (4'h8 - nelem + 4'(lofs)));
		right_be = 8'(~(EMU_ALL_ONES >> (4'h8 - nelem + 4'(rofs) + 4'h1))
			& (EMU_ALL_ONES >> (4'h8 - nelem)));
		if (little_endian_i)
		begin
			left_m = rev_n(left_be, nelem);
			right_m = rev_n(right_be, nelem);
		end
		else
		begin
			left_m = left_be;
			right_m = right_be;
		end
		// Ordering not checked: a pair with aligned start above aligned end still gives the left mask
		if (start_al != last_al)
		begin
			mask_next = left_m;
		end
		else
		begin
			mask_next = left_m & right_m;
		end
	end

	// Only a pipeline stage; nothing carries from one operation to the next
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			mask_reg <= EMU_MASK_RST;
		end
		else
		begin
			mask_reg <= mask_next;
		end
	end

	assign edge_mask_o = mask_reg;

	// Reset is also sampled in each antecedent except the width checks: at the release edge the flop still clears
	// although the disable condition has already dropped, so that edge must stay vacuous
	property p_differ_left;
		@(posedge mclk_i) disable iff (srst_i)
		(!srst_i && start_al != last_al) |=> (edge_mask_o == $past(left_m));
	endproperty
	a_differ_left: assert property (p_differ_left) else $error("differ: not left mask");

	property p_equal_and;
		@(posedge mclk_i) disable iff (srst_i)
		(!srst_i && start_al == last_al) |=> (edge_mask_o == $past(left_m & right_m));
	endproperty
	a_equal_and: assert property (p_equal_and) else $error("equal: not AND mask");

	property p_byte_ofs3;
		@(posedge mclk_i) disable iff (srst_i)
		(elem_size_i == EMU_SIZE_8 && !little_endian_i && start_elem_ptr_i[2:0] == 3'h3
			&& start_al != last_al && !srst_i) |=> (edge_mask_o == 8'h1f);
	endproperty
	a_byte_ofs3: assert property (p_byte_ofs3) else $error("byte offset 3 mask wrong");

	property p_reversed;
		@(posedge mclk_i) disable iff (srst_i)
		(!srst_i && start_al > last_al && elem_size_i == EMU_SIZE_8 && !little_endian_i)
		|=> (edge_mask_o == (8'hff >> $past(start_elem_ptr_i[2:0])));
	endproperty
	a_reversed: assert property (p_reversed) else $error("reversed pair not left mask");

	property p_le_byte;
		@(posedge mclk_i) disable iff (srst_i)
		(!srst_i && elem_size_i == EMU_SIZE_8 && little_endian_i && start_al != last_al)
		|=> (edge_mask_o == 8'(8'hff << $past(start_elem_ptr_i[2:0])));
	endproperty
	a_le_byte: assert property (p_le_byte) else $error("little-endian left mask wrong");

	property p_width16;
		@(posedge mclk_i) disable iff (srst_i)
		(elem_size_i == EMU_SIZE_16) |=> (edge_mask_o[7:4] == 4'h0);
	endproperty
	a_width16: assert property (p_width16) else $error("16-bit mask too wide");

	property p_width32;
		@(posedge mclk_i) disable iff (srst_i)
		(elem_size_i == EMU_SIZE_32) |=> (edge_mask_o[7:2] == 6'h00);
	endproperty
	a_width32: assert property (p_width32) else $error("32-bit mask too wide");

	property p_right16;
		@(posedge mclk_i) disable iff (srst_i)
		(!srst_i && elem_size_i == EMU_SIZE_16 && !little_endian_i && start_al == last_al
			&& start_elem_ptr_i[2:0] == 3'h0 && last_elem_ptr_i[2:1] == 2'h2)
		|=> (edge_mask_o == 8'h0e);
	endproperty
	a_right16: assert property (p_right16) else $error("16-bit right mask wrong");

	property p_align;
		@(posedge mclk_i) disable iff (srst_i)
		((start_elem_ptr_i[31:3] == last_elem_ptr_i[31:3]) == (start_al == last_al))
		&& start_al[2:0] == 3'h0 && last_al[2:0] == 3'h0;
	endproperty
	a_align: assert property (p_align) else $error("alignment compare wrong");

	// No disable here: the point is that reset itself leaves nothing behind
	property p_reset_clear;
		@(posedge mclk_i)
		srst_i |=> (edge_mask_o == EMU_MASK_RST);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("mask not cleared");

	property p_le_right8;
		@(posedge mclk_i) disable iff (srst_i)
		(!srst_i && elem_size_i == EMU_SIZE_8 && little_endian_i && start_al == last_al
			&& start_elem_ptr_i[2:0] == 3'h0)
		|=> (edge_mask_o == (8'hff >> (3'h7 - $past(last_elem_ptr_i[2:0]))));
	endproperty
	a_le_right8: assert property (p_le_right8) else $error("LE right mask wrong");

	property p_le16_left;
		@(posedge mclk_i) disable iff (srst_i)
		(!srst_i && elem_size_i == EMU_SIZE_16 && little_endian_i && start_al != last_al)
		|=> (edge_mask_o == {4'h0, 4'(4'hf << $past(start_elem_ptr_i[2:1]))});
	endproperty
	a_le16_left: assert property (p_le16_left) else $error("LE 16-bit left wrong");

	property p_be32_equal;
		@(posedge mclk_i) disable iff (srst_i)
		(!srst_i && elem_size_i == EMU_SIZE_32 && !little_endian_i && start_al == last_al
			&& start_elem_ptr_i[2] == 1'b0 && last_elem_ptr_i[2] == 1'b0)
		|=> (edge_mask_o == 8'h02);
	endproperty
	a_be32_equal: assert property (p_be32_equal) else $error("32-bit AND mask wrong");

	// Unused size code falls back to bytes rather than producing an empty mask
	property p_size3_byte;
		@(posedge mclk_i) disable iff (srst_i)
		(!srst_i && elem_size_i == emu_size_t'(2'b11) && !little_endian_i && start_al != last_al)
		|=> (edge_mask_o == (8'hff >> $past(start_elem_ptr_i[2:0])));
	endproperty
	a_size3_byte: assert property (p_size3_byte) else $error("size 3 not byte mask");

	c_differ: cover property (@(posedge mclk_i) disable iff (srst_i) start_al != last_al);
	c_equal: cover property (@(posedge mclk_i) disable iff (srst_i) start_al == last_al);
	c_le32: cover property (@(posedge mclk_i) disable iff (srst_i)
		little_endian_i && elem_size_i == EMU_SIZE_32);
	c_rev: cover property (@(posedge mclk_i) disable iff (srst_i) start_al > last_al);
	c_size3: cover property (@(posedge mclk_i) disable iff (srst_i)
		elem_size_i == emu_size_t'(2'b11));
endmodule

//--- emu_pipe_model.sv
// Purpose: issuing pipeline stage feeding the edge mask unit
// Assumes: one operand set launched per rising edge
// Notes: holds operands until the next issue
`timescale 1ns/10ps
module emu_pipe_model
(
	// Clock
	input wire logic mclk_i,
	// Operands
	output logic [emu_pkg::EMU_ADDR_W-1:0] start_elem_ptr_o,
	output logic [emu_pkg::EMU_ADDR_W-1:0] last_elem_ptr_o,
	output emu_pkg::emu_size_t elem_size_o,
	output logic little_endian_o
);
	import emu_pkg::*;
	initial
	begin
		start_elem_ptr_o = '0;
		last_elem_ptr_o = '0;
		elem_size_o = EMU_SIZE_8;
		little_endian_o = 1'b0;
	end
	// Start above end is only issued when ordering is under test
	task automatic issue(input logic [31:0] s, l, input logic [1:0] z, input logic e);
		@(posedge mclk_i);
		start_elem_ptr_o <= s;
		last_elem_ptr_o <= l;
		elem_size_o <= emu_size_t'(z);
		little_endian_o <= e;
	endtask
endmodule

//--- emu_pkg.sv
// Purpose: constants and types shared by the edge mask unit
// Assumes: 64-bit word of elements, byte addressed
// Notes: mask occupies the low bits of an 8-bit result
package emu_pkg;
	localparam int EMU_ADDR_W = 32;
	localparam int EMU_MASK_W = 8;
	localparam int EMU_OFS_W = 3;
	localparam logic [EMU_ADDR_W-1:0] EMU_ALIGN_CLR = 32'h0000_0007;
	localparam logic [EMU_MASK_W-1:0] EMU_MASK_RST = 8'h00;
	localparam logic [EMU_MASK_W-1:0] EMU_ALL_ONES = 8'hff;

	typedef enum logic [1:0]
	{
		EMU_SIZE_8 = 2'b00,
		EMU_SIZE_16 = 2'b01,
		EMU_SIZE_32 = 2'b10
	} emu_size_t;
endpackage

//--- test_edge_mask_unit.sv
// Purpose: self-checking bench for the edge mask unit
// Assumes: mask follows operands by one edge
// Notes: expected masks rebuilt from element count and offset
`timescale 1ns/10ps
module test_edge_mask_unit;
	import emu_pkg::*;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [31:0] sp, lp;
	emu_size_t sz;
	logic le;
	logic [7:0] mask;
	int num_errors = 0;
	int comparisons = 0;
	always #5 mclk_i = ~mclk_i;
	emu_pipe_model i_pipe (.mclk_i(mclk_i), .start_elem_ptr_o(sp), .last_elem_ptr_o(lp),
		.elem_size_o(sz), .little_endian_o(le));
	emu_edge_mask_unit i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .start_elem_ptr_i(sp),
		.last_elem_ptr_i(lp), .elem_size_i(sz), .little_endian_i(le), .edge_mask_o(mask));
	function automatic logic [7:0] em(logic [31:0] s, l, logic [1:0] z, logic e);
		int n, o, p;
		logic [7:0] f, r, v;
		n = (z == 2'h1) ? 4 : (z == 2'h2) ? 2 : 8;
		o = s[2:0] / (8 / n);
		p = l[2:0] / (8 / n);
		f = 8'hff >> (8 - n);
		r = f >> o;
		if (s[31:3] == l[31:3])
			r = r & (f << (n - 1 - p));
		v = r;
		for (int i = 0; i < n; i++)
			v[i] = r[n - 1 - i];
		return e ? v : r;
	endfunction
	task automatic cmp(input logic [7:0] x);
		comparisons++;
		if (mask !== x)
		begin
			num_errors++;
			$display("wrong value at %0t: mask %h expected %h", $time, mask, x);
		end
	endtask
	task automatic chk(input logic [31:0] s, l, input logic [1:0] z, input logic e,
		input logic [7:0] x);
		i_pipe.issue(s, l, z, e);
		@(posedge mclk_i);
		#1;
		cmp(x);
	endtask
	task automatic t_walk;
		chk(32'h0001_0003, 32'h0001_0020, 2'h0, 1'b0, 8'h1f);
		chk(32'h0001_0002, 32'h0001_0005, 2'h0, 1'b0, 8'h3c);
		chk(32'h0001_0045, 32'h0001_0003, 2'h1, 1'b0, 8'h03);
		chk(32'h8001_0005, 32'h0001_0006, 2'h0, 1'b0, 8'h07);
		chk(32'h0001_0005, 32'h0001_0006, 2'h0, 1'b1, 8'h60);
		chk(32'h0000_0104, 32'h0000_0104, 2'h2, 1'b1, 8'h02);
	endtask
	task automatic t_sweep;
		logic [31:0] s, l;
		for (int k = 0; k < 1024; k++)
		begin
			s = 32'h100 + k[2:0];
			l = 32'h100 + k[5:3] + 8 * k[6];
			chk(s, l, k[8:7], k[9], em(s, l, k[8:7], k[9]));
		end
	endtask
	task automatic t_b2b;
		i_pipe.issue(32'h0001_0000, 32'h0001_0001, 2'h0, 1'b0);
		i_pipe.issue(32'h0001_0007, 32'h0001_0040, 2'h0, 1'b0);
		#1;
		cmp(8'hc0);
		@(posedge mclk_i);
		srst_i <= 1'b1;
		#1;
		cmp(8'h01);
		@(posedge mclk_i);
		srst_i <= 1'b0;
		#1;
		cmp(EMU_MASK_RST);
	endtask
	task automatic test_done;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		num_errors++;
		test_done();
	end
	initial
	begin
		repeat (4) @(posedge mclk_i);
		srst_i <= 1'b0;
		#1;
		cmp(EMU_MASK_RST);
		t_walk();
		t_sweep();
		t_b2b();
		test_done();
	end
endmodule
